// ===== logic/ucg_pkg.sv
// Shared constants and types for the serial clock generator
package ucg_pkg;

  // Width of the baud divisor and of its down-counter
  localparam int DIV_W = 12;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_DIV_LO = 4'h4;
  localparam logic [3:0] OFF_DIV_HI = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;

  // Bit positions in the control register
  localparam int CTRL_SYNC = 0;
  localparam int CTRL_DS   = 1;
  localparam int CTRL_POL  = 2;
  localparam int CTRL_DIR  = 3;
  localparam int CTRL_PCUT = 4;
  localparam int CTRL_W    = 5;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h00;
  localparam logic [7:0]        DIV_LO_RST = 8'h00;
  localparam logic [3:0]        DIV_HI_RST = 4'h0;
  localparam logic [DIV_W-1:0]  COUNT_RST  = 12'h000;

  // Last state of a divide-by-16, -8 and -2 cycle
  localparam logic [3:0] LAST_NORM = 4'hf;
  localparam logic [3:0] LAST_DS   = 4'h7;
  localparam logic [3:0] LAST_SYNC = 4'h1;

  // Clocking modes, one-hot
  typedef enum logic [3:0] {
    MODE_ASYNC_NORM = 4'b0001,
    MODE_ASYNC_DS   = 4'b0010,
    MODE_SYNC_MAST  = 4'b0100,
    MODE_SYNC_SLAVE = 4'b1000
  } ucg_mode_e;

endpackage

// ===== logic/ucg_clk_if.sv
// Internal link between the clock core, baud counter and pin synchroniser
`timescale 1ns/1ns
interface ucg_clk_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [ucg_pkg::DIV_W-1:0] divisor;
  logic                      reload;
  logic                      run;
  logic                      baud_tick;
  logic [ucg_pkg::DIV_W-1:0] count;
  logic                      xck_level;
  logic                      xck_rise;
  logic                      xck_fall;

  modport core (input clk, rst_n, baud_tick, count, xck_level, xck_rise,
                xck_fall, output divisor, reload, run);
  modport baud (input clk, rst_n, divisor, reload, run,
                output baud_tick, count);
  modport sync (input clk, rst_n, output xck_level, xck_rise, xck_fall);
endinterface

// ===== logic/ucg_baud_gen.sv
// Programmable down-counter baud generator
`timescale 1ns/1ns
module ucg_baud_gen (
  ucg_clk_if.baud b
);

  logic [ucg_pkg::DIV_W-1:0] count_q;
  logic                      tick_q;

  // Reload on zero or on a low-byte write, else count down
  always_ff @(posedge b.clk or negedge b.rst_n) begin
    if (!b.rst_n) begin
      count_q <= ucg_pkg::COUNT_RST;
    end else if (!b.run) begin
      count_q <= count_q;
    end else if (b.reload || count_q == '0) begin
      count_q <= b.divisor;
    end else begin
      count_q <= count_q - 12'h001;
    end
  end

  // One tick per pass through zero, rate fosc/(divisor+1)
  always_ff @(posedge b.clk or negedge b.rst_n) begin
    if (!b.rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= b.run && count_q == '0;
    end
  end

  assign b.count     = count_q;
  assign b.baud_tick = tick_q;

  a_reload_write: assert property (
    @(posedge b.clk) disable iff (!b.rst_n)
    (b.run && b.reload) |=> (count_q == $past(b.divisor)))
    else $error("counter did not reload from divisor");

  a_tick_on_zero: assert property (
    @(posedge b.clk) disable iff (!b.rst_n)
    (b.run && count_q == '0) |=> tick_q && count_q == $past(b.divisor))
    else $error("baud tick missing after zero");

endmodule

// ===== logic/ucg_xck_sync.sv
// Synchroniser and edge detector for the external transfer clock
`timescale 1ns/1ns
module ucg_xck_sync (
  input  wire logic i_xck_pin,
  ucg_clk_if.sync   s
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Two flops against metastability, a third to find edges
  always_ff @(posedge s.clk or negedge s.rst_n) begin
    if (!s.rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_xck_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge pulses last one system clock each
  assign s.xck_level = sync_q;
  assign s.xck_rise  = sync_q & ~prev_q;
  assign s.xck_fall  = ~sync_q & prev_q;

  a_edge_single: assert property (
    @(posedge s.clk) disable iff (!s.rst_n)
    s.xck_rise |=> !s.xck_rise)
    else $error("rise pulse longer than one cycle");

endmodule

// ===== logic/ucg_clock_gen.sv
// Serial port clock generator with Avalon-MM control registers
`timescale 1ns/1ns
module ucg_clock_gen (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic        i_xck_pin,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_xck_o,
  output logic             o_xck_oe,
  output logic             o_tx_tick,
  output logic             o_rx_base_tick,
  output logic             o_rx_sample,
  output logic      [3:0]  o_rx_phase,
  output logic      [3:0]  o_mode
);

  logic                          rst_meta_q;
  logic                          rst_n;
  logic [ucg_pkg::CTRL_W-1:0]    ctrl_q;
  logic [7:0]                    div_lo_q;
  logic [3:0]                    div_hi_q;
  logic                          reload_q;
  ucg_pkg::ucg_mode_e            mode_q;
  ucg_pkg::ucg_mode_e            mode_d;
  logic [3:0]                    txdiv_q;
  logic [3:0]                    last;
  logic                          is_sync;
  logic                          bt;
  logic                          rise;
  logic                          fall;
  logic                          change_edge;
  logic                          sample_edge;
  logic                          rx_base;

  // Reset released through two flops; asserted at once
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ucg_clk_if clk_if (
    .clk   (i_core_clk),
    .rst_n (rst_n)
  );
  ucg_baud_gen u_baud (
    .b (clk_if.baud)
  );
  ucg_xck_sync u_sync (
    .i_xck_pin (i_xck_pin),
    .s         (clk_if.sync)
  );

  // Address decode, shared by the read and the write path
  function automatic logic hit(input logic [3:0] addr,
                               input logic [3:0] off);
    hit = addr == off;
  endfunction

  // Length of a bit cycle, minus one, for each mode
  function automatic logic [3:0] last_of(input ucg_pkg::ucg_mode_e m);
    case (m)
      ucg_pkg::MODE_ASYNC_NORM: last_of = ucg_pkg::LAST_NORM;
      ucg_pkg::MODE_ASYNC_DS:   last_of = ucg_pkg::LAST_DS;
      default:                  last_of = ucg_pkg::LAST_SYNC;
    endcase
  endfunction

  // Bus handshake: one wait cycle, then answer for one cycle
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_waitrequest <= 1'b1;
    end else if (o_avs_waitrequest && (i_avs_read || i_avs_write)) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // Read data captured in the wait cycle; unmapped reads zero
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (o_avs_waitrequest && i_avs_read) begin
      if (hit(i_avs_address, ucg_pkg::OFF_CTRL)) begin
        o_avs_readdata <= {27'h0, ctrl_q};
      end else if (hit(i_avs_address, ucg_pkg::OFF_DIV_LO)) begin
        o_avs_readdata <= {24'h0, div_lo_q};
      end else if (hit(i_avs_address, ucg_pkg::OFF_DIV_HI)) begin
        o_avs_readdata <= {28'h0, div_hi_q};
      end else if (hit(i_avs_address, ucg_pkg::OFF_STATUS)) begin
        o_avs_readdata <= {23'h0, clk_if.xck_level, o_rx_phase, mode_q};
      end else begin
        o_avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Writes land at the edge where waitrequest is seen low
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= ucg_pkg::CTRL_RST;
      div_lo_q <= ucg_pkg::DIV_LO_RST;
      div_hi_q <= ucg_pkg::DIV_HI_RST;
    end else if (!o_avs_waitrequest && i_avs_write &&
                 i_avs_byteenable[0]) begin
      if (hit(i_avs_address, ucg_pkg::OFF_CTRL)) begin
        ctrl_q <= i_avs_writedata[ucg_pkg::CTRL_W-1:0];
      end
      if (hit(i_avs_address, ucg_pkg::OFF_DIV_LO)) begin
        div_lo_q <= i_avs_writedata[7:0];
      end
      if (hit(i_avs_address, ucg_pkg::OFF_DIV_HI)) begin
        div_hi_q <= i_avs_writedata[3:0];
      end
    end
  end

  // Low-byte write restarts the counter one cycle later
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= 1'b0;
    end else begin
      reload_q <= !o_avs_waitrequest && i_avs_write &&
                  i_avs_byteenable[0] &&
                  hit(i_avs_address, ucg_pkg::OFF_DIV_LO);
    end
  end

  // Only the high byte's low nibble is kept, so the divisor spans 0-4095
  assign clk_if.divisor = {div_hi_q, div_lo_q};
  assign clk_if.reload  = reload_q;
  // Power cut holds the counter; software owns that bit
  assign clk_if.run     = !ctrl_q[ucg_pkg::CTRL_PCUT];

  // Mode decode; double speed matters only when async
  always_comb begin
    if (ctrl_q[ucg_pkg::CTRL_SYNC]) begin
      mode_d = ctrl_q[ucg_pkg::CTRL_DIR] ? ucg_pkg::MODE_SYNC_MAST
                                          : ucg_pkg::MODE_SYNC_SLAVE;
    end else if (ctrl_q[ucg_pkg::CTRL_DS]) begin
      mode_d = ucg_pkg::MODE_ASYNC_DS;
    end else begin
      mode_d = ucg_pkg::MODE_ASYNC_NORM;
    end
  end
  // Decoded mode takes effect one clock later
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= ucg_pkg::MODE_ASYNC_NORM;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign is_sync = mode_q == ucg_pkg::MODE_SYNC_MAST ||
                   mode_q == ucg_pkg::MODE_SYNC_SLAVE;
  assign last    = last_of(mode_q);
  assign bt      = clk_if.baud_tick;

  // Transfer clock edges: made here as master, taken in as slave
  always_comb begin
    case (mode_q)
      ucg_pkg::MODE_SYNC_MAST: begin
        rise = bt && !o_xck_o;
        fall = bt && o_xck_o;
      end
      ucg_pkg::MODE_SYNC_SLAVE: begin
        rise = clk_if.xck_rise && clk_if.run;
        fall = clk_if.xck_fall && clk_if.run;
      end
      default: begin
        rise = 1'b0;
        fall = 1'b0;
      end
    endcase
  end
  // Data changes on one edge and is sampled on the other
  assign change_edge = ctrl_q[ucg_pkg::CTRL_POL] ? fall : rise;
  assign sample_edge = ctrl_q[ucg_pkg::CTRL_POL] ? rise : fall;
  assign rx_base     = is_sync ? (rise || fall) : bt;

  // Master clock toggles each tick, dividing it by two
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_xck_o <= 1'b0;
    end else if (mode_q != ucg_pkg::MODE_SYNC_MAST) begin
      o_xck_o <= 1'b0;
    end else if (bt) begin
      o_xck_o <= !o_xck_o;
    end
  end

  // Pin driven only as synchronous master
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_xck_oe <= 1'b0;
    end else begin
      o_xck_oe <= mode_q == ucg_pkg::MODE_SYNC_MAST;
    end
  end

  // Transmit divider for the asynchronous modes
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txdiv_q <= 4'h0;
    end else if (mode_d != mode_q || is_sync) begin
      txdiv_q <= 4'h0;
    end else if (bt) begin
      txdiv_q <= (txdiv_q == last) ? 4'h0 : txdiv_q + 4'h1;
    end
  end

  // Transmit tick: divider wrap, or the change edge when sync
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx_tick <= 1'b0;
    end else if (is_sync) begin
      o_tx_tick <= change_edge;
    end else begin
      o_tx_tick <= bt && txdiv_q == last;
    end
  end

  // Receiver base tick: raw baud tick, or any transfer clock edge
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_base_tick <= 1'b0;
    end else begin
      o_rx_base_tick <= rx_base;
    end
  end

  // Recovery phase: 16, 8 or 2 states per bit
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_phase <= 4'h0;
    end else if (mode_d != mode_q) begin
      o_rx_phase <= 4'h0;
    end else if (rx_base) begin
      o_rx_phase <= (o_rx_phase == last) ? 4'h0 : o_rx_phase + 4'h1;
    end
  end

  // Sample at mid-bit when async; on the sample edge when sync
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rx_sample <= 1'b0;
    end else if (is_sync) begin
      o_rx_sample <= sample_edge;
    end else begin
      o_rx_sample <= bt && o_rx_phase == {1'b0, last[3:1]};
    end
  end

  // Mode is visible outside so the frame logic can follow it
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_mode <= 4'h0;
    end else begin
      o_mode <= mode_q;
    end
  end

  a_tx_div_norm: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (mode_q == ucg_pkg::MODE_ASYNC_NORM && mode_d == mode_q && bt &&
     txdiv_q == 4'he) |=> (txdiv_q == 4'hf) && !o_tx_tick)
    else $error("normal mode transmit divide not sixteen");
  a_tx_div_ds: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (mode_q == ucg_pkg::MODE_ASYNC_DS && bt && txdiv_q == 4'h7)
      |=> o_tx_tick && txdiv_q == 4'h0)
    else $error("double speed transmit divide not eight");
  a_master_toggle: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (mode_q == ucg_pkg::MODE_SYNC_MAST && mode_d == mode_q && bt)
      |=> (o_xck_o != $past(o_xck_o)))
    else $error("master transfer clock did not toggle");
  a_async_no_pin: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (!is_sync && !$past(is_sync) && !bt) |=>
      !o_xck_oe && !o_xck_o && !o_rx_base_tick && !o_tx_tick)
    else $error("transfer clock used in async mode");
  a_sync_ignores_ds: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    ctrl_q[ucg_pkg::CTRL_SYNC] |=> mode_q != ucg_pkg::MODE_ASYNC_DS)
    else $error("double speed applied in sync mode");
  a_slave_change: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (mode_q == ucg_pkg::MODE_SYNC_SLAVE && clk_if.run &&
     !ctrl_q[ucg_pkg::CTRL_POL] && clk_if.xck_rise)
      |=> o_tx_tick && !o_rx_sample)
    else $error("slave rise did not change data");
  a_pol_sample: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (is_sync && ctrl_q[ucg_pkg::CTRL_POL] && rise)
      |=> o_rx_sample && !o_tx_tick)
    else $error("set polarity did not sample on rise");
  a_rx_phase_wrap: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (mode_q == ucg_pkg::MODE_ASYNC_NORM && mode_d == mode_q && bt &&
     o_rx_phase == 4'hf) |=> o_rx_phase == 4'h0)
    else $error("receive phase did not wrap at sixteen");
  a_reload_delay: assert property (
    @(posedge i_core_clk) disable iff (!rst_n)
    (!o_avs_waitrequest && i_avs_write && i_avs_byteenable[0] &&
     i_avs_address == ucg_pkg::OFF_DIV_LO) |=> reload_q)
    else $error("low byte write did not reload counter");
endmodule

// ===== bench/ucg_xck_partner.sv
// Remote serial master that clocks the transfer clock pin in frames
`timescale 1ns/1ns
module ucg_xck_partner (
  input  wire logic i_clk,
  output logic      o_xck
);
  // Pin rests low until the first frame
  initial begin
    o_xck = 1'b0;
  end

  // One frame of edges; the pin stands still between frames
  task automatic frame(input int edges, input int half);
    int h;
    h = (half < 3) ? 3 : half; // Period above four system clocks
    for (int e = 0; e < edges; e++) begin
      repeat (h) @(posedge i_clk);
      o_xck <= ~o_xck; // Change and sample edges alternate
    end
  endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the serial port clock generator
`timescale 1ns/1ns
module testbench;
  logic        clk;
  logic        rst_n;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic        xck;
  logic        pin;
  logic [31:0] rdata;
  logic        wait_req;
  logic        xck_o;
  logic        xck_oe;
  logic        tx_tick;
  logic        rx_base;
  logic        rx_smp;
  logic [3:0]  mode;
  logic [3:0]  phase;
  int          n_fail;
  int          checks;
  logic [31:0] q;
  int          g;
  int          d;
  logic [4:0]  ctrl;
  int          cnt_tx;
  int          cnt_rx;
  logic [4:0]  tbl [6];

  // Wire level of the shared transfer clock pin
  assign pin = xck_oe ? xck_o : xck;

  ucg_clock_gen i_dut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .i_xck_pin(pin), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_xck_o(xck_o), .o_xck_oe(xck_oe),
    .o_tx_tick(tx_tick), .o_rx_base_tick(rx_base), .o_rx_sample(rx_smp),
    .o_rx_phase(phase), .o_mode(mode));

  ucg_xck_partner i_partner (.i_clk(clk), .o_xck(xck));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cut a hang short well past the expected run length
  initial begin
    #(20 * 20000);
    n_fail++;
    final_report();
  end

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, s);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] dat, input logic [3:0] en);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h000000, dat};
    be <= en;
    rd <= ~w;
    wr <= w;
    // No limit here: only the watchdog ends a stuck access
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0);
    q = rdata;
    chk("bus wait", 2, n);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return tx_tick;
      1: return rx_base;
      default: return rx_smp;
    endcase
  endfunction

  // Counts edges up to and including the next pulse, or to the limit
  task automatic wait_pulse(input int sel, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pick(sel) !== 1'b1 && n < lim);
  endtask

  function automatic int exp_gap(input logic [4:0] c, input int dv);
    if (c[0]) return 2 * (dv + 1);
    return (c[1] ? 8 : 16) * (dv + 1);
  endfunction

  function automatic logic [3:0] exp_mode(input logic [4:0] c);
    if (!c[0]) begin
      return c[1] ? ucg_pkg::MODE_ASYNC_DS : ucg_pkg::MODE_ASYNC_NORM;
    end
    return c[3] ? ucg_pkg::MODE_SYNC_MAST : ucg_pkg::MODE_SYNC_SLAVE;
  endfunction

  // Edges of a frame that change data, given start level and polarity
  function automatic int n_change(input logic st, input int e,
                                  input logic pol);
    int rises;
    rises = st ? e / 2 : (e + 1) / 2;
    return pol ? e - rises : rises;
  endfunction

  // Odd edge count makes the two polarities give different totals
  task automatic slave(input logic pol);
    logic st;
    st = xck;
    cnt_tx = 0;
    cnt_rx = 0;
    fork
      i_partner.frame(7, 3 + ($urandom % 3));
      repeat (50) begin
        @(posedge clk);
        if (tx_tick === 1'b1) cnt_tx++;
        if (rx_smp === 1'b1) cnt_rx++;
      end
    join
    chk("slave change", n_change(st, 7, pol), cnt_tx);
    chk("slave sample", 7 - n_change(st, 7, pol), cnt_rx);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h00000000;
    be = 4'hf;
    n_fail = 0;
    checks = 0;
    tbl = '{5'h00, 5'h02, 5'h01, 5'h05, 5'h09, 5'h0d};
    d = $urandom(32'h1768);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("mode", ucg_pkg::MODE_ASYNC_NORM, mode);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 4'(i * 4), 8'h00, 4'hf);
      chk("reset reg", 32'h00000000, q);
    end
    // Unmapped place and disabled byte lane leave registers alone
    bus(1'b1, 4'h2, 8'h5a, 4'hf);
    bus(1'b0, 4'h2, 8'h00, 4'hf);
    chk("unmapped", 32'h00000000, q);
    bus(1'b1, ucg_pkg::OFF_CTRL, 8'h03, 4'he);
    bus(1'b0, ucg_pkg::OFF_CTRL, 8'h00, 4'hf);
    chk("lane off", 32'h00000000, q);
    // Twelve-bit divisor; only the low byte write reloads
    bus(1'b1, ucg_pkg::OFF_DIV_HI, 8'hff, 4'hf);
    bus(1'b0, ucg_pkg::OFF_DIV_HI, 8'h00, 4'hf);
    chk("divisor high", 32'h0000000f, q);
    bus(1'b1, ucg_pkg::OFF_DIV_LO, 8'hff, 4'hf);
    bus(1'b1, ucg_pkg::OFF_DIV_HI, 8'h00, 4'hf);
    wait_pulse(1, 20, g);
    chk("no early tick", 1'b0, pick(1));
    bus(1'b1, ucg_pkg::OFF_DIV_LO, 8'h02, 4'hf);
    wait_pulse(1, 12, g);
    chk("reload tick", 1'b1, pick(1));
    wait_pulse(1, 100, g);
    chk("base gap", 3, g);
    // Power cut halts the baud counter
    bus(1'b1, ucg_pkg::OFF_CTRL, 8'h10, 4'hf);
    wait_pulse(1, 60, g);
    chk("cut tick", 1'b0, pick(1));
    foreach (tbl[i]) begin
      ctrl = tbl[i];
      d = 2 + ($urandom % 6);
      bus(1'b1, ucg_pkg::OFF_DIV_LO, 8'(d), 4'hf);
      bus(1'b1, ucg_pkg::OFF_CTRL, {3'h0, ctrl}, 4'hf);
      repeat (3) @(posedge clk);
      chk("mode", exp_mode(ctrl), mode);
      chk("pin drive", ctrl[0] & ctrl[3], xck_oe);
      bus(1'b0, ucg_pkg::OFF_STATUS, 8'h00, 4'hf);
      chk("status mode", exp_mode(ctrl), q[3:0]);
      if (ctrl[0] && !ctrl[3]) begin
        slave(ctrl[2]);
      end else if (!ctrl[0]) begin
        // Pin toggles meanwhile and must not disturb the async rate
        fork
          i_partner.frame(7, 3);
          begin
            wait_pulse(0, 5000, g);
            wait_pulse(0, 5000, g);
          end
        join
        chk("tx gap", exp_gap(ctrl, d), g);
        chk("pin out idle", 1'b0, xck_o);
        wait_pulse(1, 5000, g);
        wait_pulse(1, 5000, g);
        chk("rx base gap", d + 1, g);
        wait_pulse(2, 5000, g);
        wait_pulse(2, 5000, g);
        chk("rx sample gap", exp_gap(ctrl, d), g);
        chk("rx phase", ctrl[1] ? 4 : 8, phase);
      end else begin
        wait_pulse(0, 5000, g);
        wait_pulse(0, 5000, g);
        chk("master tx gap", exp_gap(ctrl, d), g);
        chk("level at change", !ctrl[2], xck_o);
        wait_pulse(2, 5000, g);
        chk("level at sample", ctrl[2], xck_o);
      end
    end
    final_report();
  end
endmodule
